// >>> rtl/sds_consts.svh
// Offsets, field positions, selector codes and reset values of the second diagnostic block.
`ifndef SDS_CONSTS_SVH
`define SDS_CONSTS_SVH
// Register indices; the byte address is four times the index.
`define SDS_IDX_RESULT_A_CFG    8'h6b
`define SDS_IDX_CTRL        8'h70
`define SDS_IDX_RESULT      8'h71
`define SDS_IDX_ALERT       8'h72
`define SDS_IDX_STATUS      8'h73
`define SDS_IDX_MASK        8'h74
`define SDS_ADDR_RESULT_A_CFG   12'h1ac
`define SDS_ADDR_CTRL       12'h1c0
`define SDS_ADDR_RESULT     12'h1c4
`define SDS_ADDR_ALERT      12'h1c8
`define SDS_ADDR_STATUS     12'h1cc
`define SDS_ADDR_MASK       12'h1d0
// Field positions.
`define SDS_SEL2_MSB        7
`define SDS_SEL2_LSB        4
`define SDS_CTRL_CALEN      0
`define SDS_CTRL_SCANM      1
`define SDS_ST_DONE         0
`define SDS_ST_ALERT        1
`define SDS_AL_ZERO         0
`define SDS_AL_FULL         1
// Reset values.
`define SDS_RESULT_A_CFG_RST    16'h0000
`define SDS_CTRL_RST        2'h1
// Selector codes.
`define SDS_SEL_NONE        4'h0
`define SDS_SEL_TEMP        4'h1
`define SDS_SEL_SUPPLY      4'h2
`define SDS_SEL_ALTERNATE_REFERENCE      4'h3
`define SDS_SEL_CMP_PATH    4'h4
`define SDS_SEL_CELL_CAL    4'h5
`define SDS_SEL_OFS_CAL     4'h6
`define SDS_SEL_DAC_HI      4'h7
`define SDS_SEL_DAC_LO      4'h8
`define SDS_SEL_THERMISTOR_BIAS_CAL    4'h9
`define SDS_SEL_ZERO_SCALE  4'ha
`define SDS_SEL_FULL_SCALE  4'hb
`define SDS_SEL_LSA_OFS     4'hc
// Test codes.
`define SDS_DAC_HI_CODE     10'h2ff
`define SDS_DAC_LO_CODE     10'h100
`define SDS_ZERO_EXPECT     16'h0000
`define SDS_FULL_EXPECT     16'h3ffc
// Bus answers.
`define SDS_RESP_OKAY       2'h0
`define SDS_RESP_SLVERR     2'h2
`endif

// >>> rtl/sds_pkg.sv
// Types shared by the second diagnostic selection block.
package sds_pkg;
  // Sequencer states.
  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_DONE} sds_state_t;
  // Converter input routing.
  typedef enum logic [2:0] {IN_NONE, IN_TEMP_V, IN_REF, IN_ALTERNATE_REFERENCE_LSA, IN_SHORT,
                            IN_SHORT_LSA, IN_DAC, IN_SUPPLY} sds_in_t;
  // Converter reference routing.
  typedef enum logic [1:0] {REF_MAIN, REF_SUPPLY, REF_THERM} sds_ref_t;
endpackage

// >>> rtl/sds_top.sv
// Second diagnostic measurement selection, sequencing and register slave.
// Operation
// - Selector sits at bits 7:4; code 0000 appends no diagnostic.
// - Code 0001 converts temperature voltage against main reference.
// - Code 0011 converts alternate reference through level shift amplifier.
// - Code 0100 converts main reference, bipolar, comparator path check.
// - Code 0101 cell calibration, gain and offset coefficients, chopping per method.
// - Code 0110 shorted input, bipolar, offset coefficients only.
// - Code 0111 loads DAC with 0x2ff and converts its output.
// - Code 1000 loads DAC with 0x100 and converts its output.
// - Code 1001 shorted input against thermistor bias, thermistor offset applied.
// - Result lands in the result register at acquisition end.
// - Calibration disabled selects factory coefficients; chopping applied as needed.
// - Code 1010 zero scale test expecting 0x0000, full result kept.
// - Code 1011 full scale test expecting 0x3ffc, bipolar, full result kept.
// - Code 1100 measures level shift amplifier offset, bipolar.
// - Pass or fail shows as alert bits; values only in result register.
// - Configuration register is software readable and writable, steering scans.
`timescale 1ns/100ps
`include "sds_consts.svh"

module sds_top #(
  parameter int ADDR_W   = 12,
  parameter int RES_W    = 16,
  parameter int TOL      = 4
) (
  // Clock and reset.
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Register bus, write address.
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // Register bus, write data.
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // Register bus, write response.
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // Register bus, read.
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Scan engine handshake.
  input  wire logic              scan_main_done,
  output logic                   acq_end,
  // Converter control.
  output logic                   conv_start,
  output sds_pkg::sds_in_t       conv_in_sel,
  output sds_pkg::sds_ref_t      conv_ref_sel,
  output logic                   conv_bipolar,
  output logic                   conv_chop,
  output logic                   coef_gain_apply,
  output logic                   coef_offset_apply,
  output logic                   coef_therm_apply,
  output logic                   coef_factory,
  output logic                   dac_load,
  output logic [9:0]             dac_code,
  input  wire logic              conv_valid,
  input  wire logic [RES_W-1:0]  conv_data,
  // Interrupt.
  output logic                   irq
);

  // Parameter sanity, refused at elaboration so a bad build never reaches simulation.
  if (ADDR_W < 9 || RES_W < 14 || RES_W > 32 || TOL < 0)
  begin : g_bad_param
    $error("sds_top: unsupported parameter values");
  end

  // Register state.
  logic [15:0]          result_a_cfg_r;
  logic [1:0]           ctrl_r;
  logic [RES_W-1:0]     second_result_a_result_r;
  logic [1:0]           alert_r;
  logic [1:0]           status_r;
  logic [1:0]           mask_r;
  sds_pkg::sds_state_t  state_r;
  logic [3:0]           sel_lat_r;

  // Bus handshake state.
  logic                 aw_have_r;
  logic                 w_have_r;
  logic [ADDR_W-1:0]    aw_addr_r;
  logic [31:0]          w_data_r;
  logic [3:0]           w_strb_r;
  logic                 aw_hs;
  logic                 w_hs;
  logic                 ar_hs;
  logic                 do_wr;
  logic                 bvalid_nxt;
  logic                 rvalid_nxt;
  logic                 aw_have_nxt;
  logic                 w_have_nxt;
  logic                 wr_hit;
  logic [31:0]          rd_data;
  logic                 rd_hit;

  // Event strobes and helpers.
  logic [1:0]           evt_set;
  logic [1:0]           alert_set;
  logic                 sel_valid;
  logic [3:0]           sel_cur;
  logic                 cal_en;
  logic                 ramp_method;
  logic [RES_W-1:0]     diff_zero;
  logic [RES_W-1:0]     diff_full;

  assign sel_cur     = result_a_cfg_r[`SDS_SEL2_MSB:`SDS_SEL2_LSB];
  assign cal_en      = ctrl_r[`SDS_CTRL_CALEN];
  assign ramp_method = ctrl_r[`SDS_CTRL_SCANM];
  // Only defined codes start a conversion; 0000 and the top three are skipped.
  assign sel_valid   = (sel_cur != `SDS_SEL_NONE) && (sel_cur <= `SDS_SEL_LSA_OFS);

  // Bus handshakes and write decision.
  assign aw_hs       = s_axi_awvalid & s_axi_awready;
  assign w_hs        = s_axi_wvalid & s_axi_wready;
  assign ar_hs       = s_axi_arvalid & s_axi_arready;
  assign do_wr       = aw_have_r & w_have_r & ~s_axi_bvalid;
  assign aw_have_nxt = (aw_have_r | aw_hs) & ~do_wr;
  assign w_have_nxt  = (w_have_r | w_hs) & ~do_wr;
  assign bvalid_nxt  = do_wr | (s_axi_bvalid & ~s_axi_bready);
  assign rvalid_nxt  = ar_hs | (s_axi_rvalid & ~s_axi_rready);
  assign wr_hit      = (aw_addr_r == `SDS_ADDR_RESULT_A_CFG) || (aw_addr_r == `SDS_ADDR_CTRL) ||
                       (aw_addr_r == `SDS_ADDR_MASK);

  // Ready lines drop while a transfer is held and come back once it is answered.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= ~aw_have_nxt & ~bvalid_nxt;
      s_axi_wready  <= ~w_have_nxt & ~bvalid_nxt;
      s_axi_arready <= ~rvalid_nxt;
    end
  end

  // Address and data holding; the two channels may arrive in either order.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end
    else
    begin
      aw_have_r <= aw_have_nxt;
      w_have_r  <= w_have_nxt;
      if (aw_hs)
        aw_addr_r <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
      if (w_hs)
      begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
    end
  end

  // Write response; unmapped or read-only addresses get a slave error.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SDS_RESP_OKAY;
    end
    else
    begin
      s_axi_bvalid <= bvalid_nxt;
      if (do_wr)
        s_axi_bresp <= wr_hit ? `SDS_RESP_OKAY : `SDS_RESP_SLVERR;
    end
  end

  // Software-written registers, honouring byte strobes.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      result_a_cfg_r <= `SDS_RESULT_A_CFG_RST;
      ctrl_r     <= `SDS_CTRL_RST;
      mask_r     <= 2'h0;
    end
    else if (do_wr)
    begin
      if (aw_addr_r == `SDS_ADDR_RESULT_A_CFG)
      begin
        if (w_strb_r[0])
          result_a_cfg_r[7:0] <= w_data_r[7:0];
        if (w_strb_r[1])
          result_a_cfg_r[15:8] <= w_data_r[15:8];
      end
      if (aw_addr_r == `SDS_ADDR_CTRL && w_strb_r[0])
        ctrl_r <= w_data_r[1:0];
      if (aw_addr_r == `SDS_ADDR_MASK && w_strb_r[0])
        mask_r <= w_data_r[1:0];
    end
  end

  // Read multiplexer; unused upper bits read as zero.
  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
      `SDS_ADDR_RESULT_A_CFG: rd_data[15:0]      = result_a_cfg_r;
      `SDS_ADDR_CTRL:     rd_data[1:0]       = ctrl_r;
      `SDS_ADDR_RESULT:   rd_data[RES_W-1:0] = second_result_a_result_r;
      `SDS_ADDR_ALERT:    rd_data[1:0]       = alert_r;
      `SDS_ADDR_STATUS:   rd_data[1:0]       = status_r;
      `SDS_ADDR_MASK:     rd_data[1:0]       = mask_r;
      default:            rd_hit             = 1'b0;
    endcase
  end

  // Read channel; data is captured with the address and held until taken.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `SDS_RESP_OKAY;
    end
    else
    begin
      s_axi_rvalid <= rvalid_nxt;
      if (ar_hs)
      begin
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_hit ? `SDS_RESP_OKAY : `SDS_RESP_SLVERR;
      end
    end
  end

  // Sequencer: waits for the main scan, runs the appended conversion, then ends.
  // The selector is latched at start so a write mid-conversion cannot change which scale test is judged.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r   <= sds_pkg::ST_IDLE;
      sel_lat_r <= `SDS_SEL_NONE;
    end
    else
    begin
      case (state_r)
        sds_pkg::ST_IDLE:
          if (scan_main_done)
          begin
            sel_lat_r <= sel_cur;
            state_r   <= sel_valid ? sds_pkg::ST_CONV : sds_pkg::ST_DONE;
          end
        sds_pkg::ST_CONV:
          if (conv_valid)
            state_r <= sds_pkg::ST_DONE;
        sds_pkg::ST_DONE:
          state_r <= sds_pkg::ST_IDLE;
        default:
          state_r <= sds_pkg::ST_IDLE;
      endcase
    end
  end

  // Routing and coefficient controls, decoded once per appended conversion.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      conv_start        <= 1'b0;
      conv_in_sel       <= sds_pkg::IN_NONE;
      conv_ref_sel      <= sds_pkg::REF_MAIN;
      conv_bipolar      <= 1'b0;
      conv_chop         <= 1'b0;
      coef_gain_apply   <= 1'b0;
      coef_offset_apply <= 1'b0;
      coef_therm_apply  <= 1'b0;
      coef_factory      <= 1'b0;
      dac_load          <= 1'b0;
      dac_code          <= 10'h000;
    end
    else
    begin
      conv_start <= 1'b0;
      dac_load   <= 1'b0;
      if (state_r == sds_pkg::ST_IDLE && scan_main_done && sel_valid)
      begin
        conv_start        <= 1'b1;
        conv_in_sel       <= sds_pkg::IN_REF;
        conv_ref_sel      <= sds_pkg::REF_MAIN;
        conv_bipolar      <= 1'b0;
        conv_chop         <= 1'b0;
        coef_gain_apply   <= 1'b0;
        coef_offset_apply <= 1'b0;
        coef_therm_apply  <= 1'b0;
        coef_factory      <= ~cal_en;
        case (sel_cur)
          `SDS_SEL_TEMP:   conv_in_sel <= sds_pkg::IN_TEMP_V;
          `SDS_SEL_SUPPLY: conv_ref_sel <= sds_pkg::REF_SUPPLY;
          `SDS_SEL_ALTERNATE_REFERENCE: conv_in_sel <= sds_pkg::IN_ALTERNATE_REFERENCE_LSA;
          `SDS_SEL_CMP_PATH: conv_bipolar <= 1'b1;
          `SDS_SEL_CELL_CAL:
          begin
            coef_gain_apply   <= 1'b1;
            coef_offset_apply <= 1'b1;
            conv_chop         <= ~ramp_method;
          end
          `SDS_SEL_OFS_CAL:
          begin
            conv_in_sel       <= ramp_method ? sds_pkg::IN_SHORT_LSA : sds_pkg::IN_SHORT;
            conv_bipolar      <= 1'b1;
            coef_offset_apply <= 1'b1;
            conv_chop         <= ~ramp_method;
          end
          `SDS_SEL_DAC_HI:
          begin
            conv_in_sel <= sds_pkg::IN_DAC;
            dac_load    <= 1'b1;
            dac_code    <= `SDS_DAC_HI_CODE;
          end
          `SDS_SEL_DAC_LO:
          begin
            conv_in_sel <= sds_pkg::IN_DAC;
            dac_load    <= 1'b1;
            dac_code    <= `SDS_DAC_LO_CODE;
          end
          `SDS_SEL_THERMISTOR_BIAS_CAL:
          begin
            conv_in_sel      <= sds_pkg::IN_SHORT;
            conv_ref_sel     <= sds_pkg::REF_THERM;
            conv_bipolar     <= 1'b1;
            coef_therm_apply <= 1'b1;
          end
          `SDS_SEL_ZERO_SCALE:
          begin
            conv_in_sel  <= sds_pkg::IN_SUPPLY;
            conv_bipolar <= 1'b1;
          end
          `SDS_SEL_FULL_SCALE:
          begin
            conv_in_sel  <= sds_pkg::IN_SUPPLY;
            conv_bipolar <= 1'b1;
          end
          `SDS_SEL_LSA_OFS:
          begin
            conv_in_sel  <= sds_pkg::IN_SHORT_LSA;
            conv_bipolar <= 1'b1;
          end
          default: conv_in_sel <= sds_pkg::IN_REF;
        endcase
      end
    end
  end

  // Distance of the sample from each expected test code.
  assign diff_zero = (conv_data >= RES_W'(`SDS_ZERO_EXPECT)) ?
                     conv_data - RES_W'(`SDS_ZERO_EXPECT) : RES_W'(`SDS_ZERO_EXPECT) - conv_data;
  assign diff_full = (conv_data >= RES_W'(`SDS_FULL_EXPECT)) ?
                     conv_data - RES_W'(`SDS_FULL_EXPECT) : RES_W'(`SDS_FULL_EXPECT) - conv_data;

  // Result capture; the full code is kept whether the test passes or not.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      second_result_a_result_r <= '0;
    else if (state_r == sds_pkg::ST_CONV && conv_valid)
      second_result_a_result_r <= conv_data;
  end

  // Pass or fail outcome of the scale tests; a new run overwrites its own bit only.
  always_comb
  begin
    alert_set = 2'b00;
    if (state_r == sds_pkg::ST_CONV && conv_valid)
    begin
      if (sel_lat_r == `SDS_SEL_ZERO_SCALE)
        alert_set[`SDS_AL_ZERO] = diff_zero > RES_W'(TOL);
      if (sel_lat_r == `SDS_SEL_FULL_SCALE)
        alert_set[`SDS_AL_FULL] = diff_full > RES_W'(TOL);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      alert_r <= 2'b00;
    else if (state_r == sds_pkg::ST_CONV && conv_valid)
    begin
      if (sel_lat_r == `SDS_SEL_ZERO_SCALE)
        alert_r[`SDS_AL_ZERO] <= alert_set[`SDS_AL_ZERO];
      if (sel_lat_r == `SDS_SEL_FULL_SCALE)
        alert_r[`SDS_AL_FULL] <= alert_set[`SDS_AL_FULL];
    end
  end

  // End of acquisition pulse, one cycle after the result is stored.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      acq_end <= 1'b0;
    else
      acq_end <= (state_r == sds_pkg::ST_DONE);
  end

  // Sticky status: a read clears it, but an event in the same cycle still sets.
  assign evt_set[`SDS_ST_DONE]  = (state_r == sds_pkg::ST_DONE);
  assign evt_set[`SDS_ST_ALERT] = |alert_set;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status_r <= 2'b00;
    else if (ar_hs && {s_axi_araddr[ADDR_W-1:2], 2'b00} == `SDS_ADDR_STATUS)
      status_r <= evt_set;
    else
      status_r <= status_r | evt_set;
  end

  // Level interrupt, registered so it never glitches.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(status_r & mask_r);
  end

endmodule

// >>> sim/sds_top_sva.sv
// Port-level assertions for the second diagnostic selection block.
`timescale 1ns/100ps
`include "sds_consts.svh"

module sds_top_sva (
  // Clock and reset.
  input wire logic              aclk,
  input wire logic              aresetn,
  // Scan engine and converter.
  input wire logic              scan_main_done,
  input wire logic              acq_end,
  input wire logic              conv_start,
  input wire sds_pkg::sds_in_t  conv_in_sel,
  input wire sds_pkg::sds_ref_t conv_ref_sel,
  input wire logic              conv_bipolar,
  input wire logic              coef_therm_apply,
  input wire logic              coef_factory,
  input wire logic              dac_load,
  input wire logic [9:0]        dac_code,
  input wire logic              conv_valid,
  // Register bus handshakes.
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic              s_axi_rvalid
);
  logic busy_r;
  logic conv_r;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Tracks an accepted request, so pulses refused while busy are not taken as new ones.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      busy_r <= 1'b0;
    else if (acq_end)
      busy_r <= 1'b0;
    else if (scan_main_done)
      busy_r <= 1'b1;
  end

  // Open conversion window; a result outside it must be ignored.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      conv_r <= 1'b0;
    else if (conv_start)
      conv_r <= 1'b1;
    else if (conv_valid)
      conv_r <= 1'b0;
  end

  start_or_end_a : assert property (
    !busy_r && scan_main_done |-> ##1 conv_start or ##2 acq_end)
    else $error("request neither started nor ended in time");
  start_pulse_a : assert property (conv_start |=> !conv_start)
    else $error("conversion start longer than one cycle");
  result_end_a : assert property (conv_r && conv_valid |-> ##2 acq_end)
    else $error("acquisition end late after result");
  end_pulse_a : assert property (acq_end |=> !acq_end)
    else $error("acquisition end longer than one cycle");
  dac_load_a : assert property (
    dac_load |-> conv_start && conv_in_sel == sds_pkg::IN_DAC &&
    (dac_code == `SDS_DAC_HI_CODE || dac_code == `SDS_DAC_LO_CODE))
    else $error("dac load without matching start or code");
  therm_cal_a : assert property (
    conv_start && conv_ref_sel == sds_pkg::REF_THERM |->
    conv_in_sel == sds_pkg::IN_SHORT && conv_bipolar && coef_therm_apply)
    else $error("thermistor calibration set up wrongly");
  scale_test_a : assert property (
    conv_start && conv_in_sel == sds_pkg::IN_SUPPLY |->
    conv_bipolar && conv_ref_sel == sds_pkg::REF_MAIN)
    else $error("scale test not bipolar against main reference");
  factory_hold_a : assert property (!conv_start |-> $stable(coef_factory))
    else $error("factory coefficient flag moved between starts");
  read_answer_a : assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  write_close_a : assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not withdrawn");
endmodule

// >>> sim/second_result_a_measure_select_tb.sv
// Self-checking bench for the second diagnostic selection block.
`timescale 1ns/100ps
`include "sds_consts.svh"

module second_result_a_measure_select_tb;
  localparam int TOL = 4;
  // Design pins.
  logic              aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic              s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic              s_axi_arready, s_axi_rvalid, s_axi_rready, scan_main_done;
  logic              acq_end, conv_start, conv_bipolar, conv_chop, coef_gain_apply;
  logic              coef_offset_apply, coef_therm_apply, coef_factory, dac_load;
  logic              conv_valid, irq;
  logic [11:0]       s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0]        s_axi_wstrb, ccf;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rsp;
  logic [9:0]        dac_code, cdc;
  logic [15:0]       conv_data;
  sds_pkg::sds_in_t  conv_in_sel, cin;
  sds_pkg::sds_ref_t conv_ref_sel, cref;
  // Bench state.
  logic              cbip, cfac, cdl, ended;
  int                n_fail, cmp_count, cyc, nst, k;
  // Per code: {input route, bipolar}, {reference, 2'b00}, {gain, offset, therm, chop}, mask.
  logic [15:0]       rows [16] = '{16'h0000, 16'h2000, 16'h4400, 16'h6000, 16'h5000,
    16'h40df, 16'h905f, 16'hc000, 16'hc000, 16'h9822, 16'hf000, 16'hf000, 16'hb000,
    16'h0000, 16'h0000, 16'h0000};

  sds_top #(.TOL(TOL)) u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .scan_main_done, .acq_end, .conv_start, .conv_in_sel,
    .conv_ref_sel, .conv_bipolar, .conv_chop, .coef_gain_apply, .coef_offset_apply,
    .coef_therm_apply, .coef_factory, .dac_load, .dac_code, .conv_valid, .conv_data, .irq);

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string t);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, t, g, e);
    end
  endtask

  // Write holds each channel until its ready is sampled, bready until bvalid.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // One acquisition; a repeat request while busy must be ignored, so starts are counted.
  task automatic run(input logic [3:0] s, input logic [15:0] d);
    wr(`SDS_ADDR_RESULT_A_CFG, {24'h0, s, 4'h0}, rsp);
    scan_main_done <= 1'b1;
    nst = 0;
    ended = 1'b0;
    for (int n = 0; n < 30 && !ended; n++)
    begin
      @(posedge aclk);
      scan_main_done <= conv_start;
      conv_valid <= conv_start;
      conv_data <= d;
      if (conv_start)
      begin
        nst++;
        cin = conv_in_sel;
        cref = conv_ref_sel;
        cbip = conv_bipolar;
        ccf = {coef_gain_apply, coef_offset_apply, coef_therm_apply, conv_chop};
        cfac = coef_factory;
        cdl = dac_load;
        cdc = dac_code;
      end
      ended = acq_end;
    end
    @(posedge aclk);
  endtask

  // Clock of 10 ns.
  always #5 aclk = ~aclk;

  // Cuts a hung run short; the tests need well under this many cycles.
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end

  // Main sequence: table of codes first, then the awkward cases.
  initial
  begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, scan_main_done, conv_valid, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, conv_data} = '0;
    s_axi_wstrb = 4'hf;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (k = 0; k < 16; k++)
    begin
      run(k[3:0], 16'h1000 + k[15:0]);
      chk(nst, rows[k][15:13] != 3'h0, "start count");
      if (nst != 0)
      begin
        chk(cin, rows[k][15:13], "input route");
        chk(cref, rows[k][11:10], "reference route");
        chk(cbip, rows[k][12], "bipolar mode");
        chk(ccf & rows[k][3:0], rows[k][7:4], "coefficient flags");
        chk(cfac, 1'b0, "factory flag");
        chk(cdl, rows[k][15:13] == 3'h6, "dac load");
        if (cdl) chk(cdc, (k == 7) ? `SDS_DAC_HI_CODE : `SDS_DAC_LO_CODE, "dac code");
        rd(`SDS_ADDR_RESULT, rdat, rsp);
        chk(rdat, 32'h1000 + k, "result register");
      end
      $display("selector %0h test done", k);
    end
    // Ramp method with calibration off: no chopping, factory coefficients, amp path.
    wr(`SDS_ADDR_CTRL, 32'h2, rsp);
    run(4'h6, 16'h0);
    chk(cin, sds_pkg::IN_SHORT_LSA, "ramp offset route");
    chk(ccf, 4'h4, "ramp offset flags");
    chk(cfac, 1'b1, "factory flag");
    run(4'h5, 16'h0);
    chk(ccf, 4'hc, "ramp cell flags");
    wr(`SDS_ADDR_CTRL, 32'h1, rsp);
    $display("ramp test done");
    // Scale tests at the tolerance edge and the alert interrupt.
    wr(`SDS_ADDR_MASK, 32'h3, rsp);
    rd(`SDS_ADDR_STATUS, rdat, rsp);
    run(4'ha, 16'(TOL));
    rd(`SDS_ADDR_ALERT, rdat, rsp);
    chk(rdat, 32'h2, "zero scale pass");
    run(4'hb, `SDS_FULL_EXPECT - 16'(TOL));
    rd(`SDS_ADDR_ALERT, rdat, rsp);
    chk(rdat, 32'h0, "full scale pass");
    run(4'ha, 16'(TOL + 1));
    rd(`SDS_ADDR_ALERT, rdat, rsp);
    chk(rdat, 32'h1, "zero scale fail");
    repeat (2) @(posedge aclk);
    chk(irq, 1'b1, "irq raised");
    rd(`SDS_ADDR_STATUS, rdat, rsp);
    chk(rdat, 32'h3, "status events");
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0, "irq cleared by read");
    wr(`SDS_ADDR_MASK, 32'h0, rsp);
    run(4'h1, 16'h0);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0, "irq masked");
    rd(`SDS_ADDR_STATUS, rdat, rsp);
    chk(rdat, 32'h1, "done event");
    $display("alert test done");
    // Register access: read back, read-only target and unmapped address.
    wr(`SDS_ADDR_RESULT_A_CFG, 32'ha5f3, rsp);
    chk(rsp, `SDS_RESP_OKAY, "config write");
    rd(`SDS_ADDR_RESULT_A_CFG, rdat, rsp);
    chk(rdat, 32'ha5f3, "config read back");
    s_axi_wstrb <= 4'h2;
    wr(`SDS_ADDR_RESULT_A_CFG, 32'h5a00, rsp);
    s_axi_wstrb <= 4'hf;
    rd(`SDS_ADDR_RESULT_A_CFG, rdat, rsp);
    chk(rdat, 32'h5af3, "byte strobe write");
    wr(`SDS_ADDR_RESULT, 32'h1, rsp);
    chk(rsp, `SDS_RESP_SLVERR, "read-only write");
    rd(12'h000, rdat, rsp);
    chk(rsp, `SDS_RESP_SLVERR, "unmapped read");
    $display("bus test done");
    // Second reset in mid-run restores every register.
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`SDS_ADDR_RESULT_A_CFG, rdat, rsp);
    chk(rdat, 32'h0, "config reset");
    for (k = 0; k < 5; k++)
    begin
      rd(`SDS_ADDR_CTRL + 12'(4 * k), rdat, rsp);
      chk(rdat, (k == 0) ? 32'h1 : 32'h0, "register reset");
    end
    chk(irq, 1'b0, "irq after reset");
    $display("reset test done");
    tally_and_finish();
  end
endmodule

bind sds_top sds_top_sva u_sva (
  .aclk, .aresetn, .scan_main_done, .acq_end, .conv_start, .conv_in_sel, .conv_ref_sel,
  .conv_bipolar, .coef_therm_apply, .coef_factory, .dac_load, .dac_code, .conv_valid,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
